//--- hdl/rmt_pkg.sv
package rmt_pkg;

   // apb register byte addresses
   localparam logic [7:0] ADDR_CTRL      = 8'h00;
   localparam logic [7:0] ADDR_OWN_SHORT = 8'h04;
   localparam logic [7:0] ADDR_DEST_HI   = 8'h08;
   localparam logic [7:0] ADDR_DEST_LO   = 8'h0C;
   localparam logic [7:0] ADDR_SERIAL_HI = 8'h10;
   localparam logic [7:0] ADDR_SERIAL_LO = 8'h14;
   localparam logic [7:0] ADDR_TIMING    = 8'h18;
   localparam logic [7:0] ADDR_STATUS    = 8'h1C;
   localparam logic [7:0] ADDR_SRC_LO    = 8'h20;
   localparam logic [7:0] ADDR_SRC_HI    = 8'h24;
   localparam logic [7:0] ADDR_DST_LO    = 8'h28;
   localparam logic [7:0] ADDR_COMMAND   = 8'h2C;

   // ctrl field positions
   localparam int CTRL_RETRY_LSB = 0;
   localparam int CTRL_CCA_LSB   = 4;
   localparam int CTRL_BE_LSB    = 12;
   localparam int CTRL_COORD_BIT = 16;
   localparam int CTRL_PINPOLL   = 17;
   localparam int CTRL_MACMODE   = 18;

   // command bits
   localparam int CMD_FORCE_POLL = 0;
   localparam int CMD_ASSOC_DONE = 1;
   localparam int CMD_CLR_STATUS = 2;

   // address constants
   localparam logic [15:0] SHORT_NONE_A   = 16'hFFFF;
   localparam logic [15:0] SHORT_NONE_B   = 16'hFFFE;
   localparam logic [31:0] BCAST_LO       = 32'h0000FFFF;
   localparam logic [31:0] ZERO_WORD      = 32'h00000000;

   // retry figures and queue depth
   localparam logic [3:0] ACK_RETRIES     = 4'h3;
   localparam logic [3:0] CCA_RETRIES     = 4'h2;
   localparam logic [3:0] BCAST_EXTRA     = 4'h2;
   localparam int          QUEUE_DEPTH    = 2;

   // reset values
   localparam logic [31:0] CTRL_RESET     = 32'h0000_3028;
   localparam logic [15:0] OWN_RESET      = 16'h0000;

   typedef enum logic [2:0] {
      RMT_IDLE, RMT_BACKOFF, RMT_CCA, RMT_SEND, RMT_WAIT_ACK, RMT_DONE
   } rmt_state_t;

   // frame header going out to the radio
   typedef struct packed {
      logic        src_long;
      logic [63:0] src;
      logic        dst_long;
      logic        bcast;
      logic [63:0] dst;
      logic        indirect;
   } rmt_hdr_t;

   // one queued indirect message
   typedef struct packed {
      logic        valid;
      logic [63:0] dst;
      logic [31:0] age;
   } rmt_slot_t;

endpackage

//--- hdl/rmt_tx_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module rmt_tx_ctrl #(
   parameter logic [63:0] FACTORY_SERIAL = 64'h0123_4567_89AB_CDEF, // arbitrary value
   parameter int          SLOT_US_CYC    = 64
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // host serial buffer and mode events
   input  wire logic        tx_req,
   output logic             tx_busy,
   input  wire logic        rx_valid,
   input  wire logic        rx_bcast,
   input  wire logic        rx_for_me,
   input  wire logic [63:0] rx_src,
   input  wire logic        rx_is_poll,
   input  wire logic        sleep_cond,
   input  wire logic        cmd_seq,
   input  wire logic        cyclic_wake,
   input  wire logic        pin_wake,
   // radio side
   input  wire logic [7:0]  channel_energy,
   input  wire logic        ack_rcvd,
   input  wire logic        send_done,
   output logic             send_strobe,
   output rmt_pkg::rmt_hdr_t hdr,
   output logic             ack_send,
   output logic             rx_accept,
   output logic             poll_send,
   output logic [1:0]       op_mode
);

   logic [31:0] ctrl;
   logic [15:0] own_short_address;
   logic [31:0] destination_high_word, destination_low_word;
   logic [31:0] timing;              // [15:0] sleep period, [31:16] idle time before sleep
   logic [3:0]  status;              // 0 done 1 ack fail 2 cca fail 3 queue reject
   rmt_pkg::rmt_state_t state;
   logic [3:0]  ack_cnt, cca_cnt;
   logic [4:0]  sends_left;          // one bit wider: a retry setting of 15 asks for 17 sends
   logic [15:0] lfsr;
   logic [15:0] wait_cnt;
   logic        pkt_bcast, pkt_indirect;
   logic [63:0] pkt_dst;
   rmt_pkg::rmt_slot_t slot [rmt_pkg::QUEUE_DEPTH];
   logic [63:0] awake_addr;
   logic [31:0] awake_cnt;
   logic        awake_vld;

   wire logic        apb_wr  = psel && penable && pwrite;
   wire logic        apb_rd  = psel && !penable && !pwrite;
   wire logic [3:0]  unicast_retry_setting    = ctrl[rmt_pkg::CTRL_RETRY_LSB +: 4];
   wire logic [7:0]  channel_energy_threshold = ctrl[rmt_pkg::CTRL_CCA_LSB +: 8];
   wire logic [3:0]  backoff_exponent_setting = ctrl[rmt_pkg::CTRL_BE_LSB +: 4];
   wire logic        coord_en                 = ctrl[rmt_pkg::CTRL_COORD_BIT];
   wire logic        end_device_association_flags = ctrl[rmt_pkg::CTRL_PINPOLL];
   wire logic        mac_mode_select          = ctrl[rmt_pkg::CTRL_MACMODE];
   wire logic [15:0] cyclic_sleep_period      = timing[15:0];
   wire logic [15:0] idle_time_before_sleep   = timing[31:16];
   wire logic        cmd_wr = apb_wr && paddr == rmt_pkg::ADDR_COMMAND;
   wire logic        force_poll_command = cmd_wr && pwdata[rmt_pkg::CMD_FORCE_POLL];

   // source selection shared by header build and readback
   function automatic logic src_is_long(input logic [15:0] s);
      return s == rmt_pkg::SHORT_NONE_A || s == rmt_pkg::SHORT_NONE_B;
   endfunction

   wire logic        src_long = src_is_long(own_short_address);
   wire logic [63:0] src_addr = src_long ? FACTORY_SERIAL : {48'h0, own_short_address};
   wire logic [63:0] dst_addr = {destination_high_word, destination_low_word};
   wire logic        dst_bc   = destination_high_word == rmt_pkg::ZERO_WORD
                                && destination_low_word == rmt_pkg::BCAST_LO;
   wire logic        dst_short = destination_high_word == rmt_pkg::ZERO_WORD
                                && destination_low_word < {16'h0, rmt_pkg::SHORT_NONE_B};
   wire logic        dst_awake = awake_vld && awake_addr == dst_addr;
   // coordinator queues only when sleep is on and target asleep
   wire logic        go_indirect = coord_en && cyclic_sleep_period != 16'h0 && !dst_bc && !dst_awake;
   wire logic        q_full   = slot[0].valid && slot[1].valid;
   wire logic        cca_busy = channel_energy > channel_energy_threshold;
   wire logic        poll_hit0 = rx_valid && rx_is_poll && slot[0].valid && slot[0].dst == rx_src;
   wire logic        poll_hit1 = rx_valid && rx_is_poll && slot[1].valid && slot[1].dst == rx_src;

   // register writes
   always_ff @(posedge clk)
      if (!rst_n)
      begin
         ctrl <= rmt_pkg::CTRL_RESET;
         own_short_address <= rmt_pkg::OWN_RESET;
         destination_high_word <= rmt_pkg::ZERO_WORD;
         destination_low_word <= rmt_pkg::ZERO_WORD;
         timing <= rmt_pkg::ZERO_WORD;
      end
      else if (cmd_wr && pwdata[rmt_pkg::CMD_ASSOC_DONE])
         own_short_address <= rmt_pkg::SHORT_NONE_B;
      else if (apb_wr)
         unique case (paddr)
            rmt_pkg::ADDR_CTRL:      ctrl <= pwdata;
            rmt_pkg::ADDR_OWN_SHORT: own_short_address <= pwdata[15:0];
            rmt_pkg::ADDR_DEST_HI:   destination_high_word <= pwdata;
            rmt_pkg::ADDR_DEST_LO:   destination_low_word <= pwdata;
            rmt_pkg::ADDR_TIMING:    timing <= pwdata;
            default: ;                                                                            // serial words ignore writes
         endcase

   // read data captured in setup so access phase completes at once
   always_ff @(posedge clk)
      if (!rst_n)
         prdata <= rmt_pkg::ZERO_WORD;
      else if (apb_rd)
         unique case (paddr)
            rmt_pkg::ADDR_CTRL:      prdata <= ctrl;
            rmt_pkg::ADDR_OWN_SHORT: prdata <= {16'h0, own_short_address};
            rmt_pkg::ADDR_DEST_HI:   prdata <= destination_high_word;
            rmt_pkg::ADDR_DEST_LO:   prdata <= destination_low_word;
            rmt_pkg::ADDR_SERIAL_HI: prdata <= FACTORY_SERIAL[63:32];
            rmt_pkg::ADDR_SERIAL_LO: prdata <= FACTORY_SERIAL[31:0];
            rmt_pkg::ADDR_TIMING:    prdata <= timing;
            rmt_pkg::ADDR_STATUS:    prdata <= {24'h0, 1'b0, q_full, dst_bc, dst_short, status};
            rmt_pkg::ADDR_SRC_LO:    prdata <= src_addr[31:0];
            rmt_pkg::ADDR_SRC_HI:    prdata <= {31'h0, src_long};
            rmt_pkg::ADDR_DST_LO:    prdata <= dst_addr[31:0];
            default:                 prdata <= rmt_pkg::ZERO_WORD;
         endcase

   assign pready  = 1'b1;
   assign pslverr = 1'b0;

   // pseudo random source for backoff
   always_ff @(posedge clk)
      if (!rst_n)
         lfsr <= 16'hACE1;
      else
         lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};

   // backoff length: random slots under 2^be, each SLOT_US_CYC cycles
   function automatic logic [15:0] backoff_len(input logic [3:0] be, input logic [15:0] r);
      logic [15:0] mask;
      mask = (16'h1 << be) - 16'h1;
      return (r & mask) * 16'(SLOT_US_CYC);
   endfunction

   // transmit sequencer
   always_ff @(posedge clk)
      if (!rst_n)
      begin
         state <= rmt_pkg::RMT_IDLE;
         ack_cnt <= 4'h0;
         cca_cnt <= 4'h0;
         sends_left <= 5'h00;
         wait_cnt <= 16'h0;
         pkt_bcast <= 1'b0;
         pkt_indirect <= 1'b0;
         pkt_dst <= 64'h0;
         status <= 4'h0;
      end
      else
      begin
         if (cmd_wr && pwdata[rmt_pkg::CMD_CLR_STATUS])
            status <= 4'h0;
         unique case (state)
            rmt_pkg::RMT_IDLE:
               if (tx_req)
               begin
                  ack_cnt <= 4'h0;
                  cca_cnt <= 4'h0;
                  pkt_bcast <= dst_bc;
                  pkt_dst <= dst_addr;
                  pkt_indirect <= go_indirect;
                  sends_left <= (dst_bc && unicast_retry_setting != 4'h0)
                                ? {1'b0, unicast_retry_setting} + {1'b0, rmt_pkg::BCAST_EXTRA}
                                : 5'h01;
                  if (go_indirect && q_full)
                  begin
                     status[3] <= 1'b1;
                     state <= rmt_pkg::RMT_DONE;
                  end
                  else if (go_indirect)
                     state <= rmt_pkg::RMT_DONE;
                  else
                  begin
                     wait_cnt <= backoff_len(backoff_exponent_setting, lfsr);
                     state <= rmt_pkg::RMT_BACKOFF;
                  end
               end
            rmt_pkg::RMT_BACKOFF:
               if (wait_cnt == 16'h0)
                  state <= rmt_pkg::RMT_CCA;
               else
                  wait_cnt <= wait_cnt - 16'h1;
            rmt_pkg::RMT_CCA:
               if (!cca_busy)
                  state <= rmt_pkg::RMT_SEND;
               // default mac mode retries only broadcast or zero-retry unicast
               else if (!mac_mode_select && (pkt_bcast || unicast_retry_setting == 4'h0)
                        && cca_cnt < rmt_pkg::CCA_RETRIES)
               begin
                  cca_cnt <= cca_cnt + 4'h1;
                  wait_cnt <= backoff_len(backoff_exponent_setting, lfsr);
                  state <= rmt_pkg::RMT_BACKOFF;
               end
               else
               begin
                  status[2] <= 1'b1;
                  state <= rmt_pkg::RMT_DONE;
               end
            rmt_pkg::RMT_SEND:
               if (send_done)
               begin
                  if (!pkt_bcast)
                     state <= rmt_pkg::RMT_WAIT_ACK;
                  else if (sends_left > 5'h01)
                  begin
                     sends_left <= sends_left - 5'h01;
                     state <= rmt_pkg::RMT_BACKOFF;
                  end
                  else
                     state <= rmt_pkg::RMT_DONE;
               end
            rmt_pkg::RMT_WAIT_ACK:
               if (ack_rcvd)
                  state <= rmt_pkg::RMT_DONE;
               else if (rx_valid || wait_cnt == 16'hFFFF)
               begin
                  wait_cnt <= 16'h0;
                  if (ack_cnt < rmt_pkg::ACK_RETRIES)
                  begin
                     ack_cnt <= ack_cnt + 4'h1;
                     state <= rmt_pkg::RMT_BACKOFF;
                  end
                  else
                  begin
                     status[1] <= 1'b1;
                     state <= rmt_pkg::RMT_DONE;
                  end
               end
               else
                  wait_cnt <= wait_cnt + 16'h1;
            rmt_pkg::RMT_DONE:
            begin
               status[0] <= 1'b1;
               state <= rmt_pkg::RMT_IDLE;
            end
            default: state <= rmt_pkg::RMT_IDLE;
         endcase
      end

   // indirect queue: fill on entry, free on poll or expiry
   always_ff @(posedge clk)
      if (!rst_n)
      begin
         slot[0] <= '0;
         slot[1] <= '0;
      end
      else
         for (int i = 0; i < rmt_pkg::QUEUE_DEPTH; i++)
         begin
            if (state == rmt_pkg::RMT_IDLE && tx_req && go_indirect && !q_full
                && (i == 0 ? !slot[0].valid : slot[0].valid && !slot[1].valid))
               slot[i] <= '{valid: 1'b1, dst: dst_addr, age: 32'h0};
            else if ((i == 0 ? poll_hit0 : poll_hit1)
                     || slot[i].age >= {16'h0, cyclic_sleep_period} * 32'(SLOT_US_CYC))
               slot[i].valid <= 1'b0;
            else if (slot[i].valid)
               slot[i].age <= slot[i].age + 32'h1;
         end

   // awake window after addressed traffic from a node
   always_ff @(posedge clk)
      if (!rst_n)
      begin
         awake_vld <= 1'b0;
         awake_addr <= 64'h0;
         awake_cnt <= 32'h0;
      end
      else if (rx_valid && rx_for_me && !rx_bcast)
      begin
         awake_vld <= 1'b1;
         awake_addr <= rx_src;
         awake_cnt <= 32'h0;
      end
      else if (awake_cnt >= {16'h0, idle_time_before_sleep} * 32'(SLOT_US_CYC))
         awake_vld <= 1'b0;
      else
         awake_cnt <= awake_cnt + 32'h1;

   // radio strobes and mode
   always_ff @(posedge clk)
      if (!rst_n)
      begin
         ack_send <= 1'b0;
         rx_accept <= 1'b0;
         poll_send <= 1'b0;
         op_mode <= 2'h0;
      end
      else
      begin
         rx_accept <= rx_valid && (rx_bcast || rx_for_me);
         ack_send <= rx_valid && rx_for_me && !rx_bcast && !rx_is_poll;
         poll_send <= !coord_en && (cyclic_wake || (pin_wake && end_device_association_flags)
                      || force_poll_command);
         // 0 idle, 1 busy, 2 sleep, 3 command
         op_mode <= cmd_seq ? 2'h3 : (state != rmt_pkg::RMT_IDLE || rx_valid) ? 2'h1
                    : sleep_cond ? 2'h2 : 2'h0;
      end

   assign send_strobe = state == rmt_pkg::RMT_CCA && !cca_busy;
   assign tx_busy     = state != rmt_pkg::RMT_IDLE;

   // header presented to the radio
   always_ff @(posedge clk)
      if (!rst_n)
         hdr <= '0;
      else
         hdr <= '{src_long: src_long, src: src_addr, dst_long: !dst_short && !dst_bc,
                  bcast: dst_bc, dst: dst_addr, indirect: go_indirect};

endmodule
`default_nettype wire

//--- testbench/rmt_radio_model.sv
`timescale 1ns/1ps
`default_nettype none
module rmt_radio_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // radio handshake
   input wire logic send_strobe,
   input wire logic ack_en,
   input wire logic slow,
   output logic     send_done,
   output logic     ack_rcvd,
   output logic     stray_rx,
   output int       sends
);
   logic [7:0] cnt;
   // air time, then the peer answer; a lost ack shows up as foreign traffic
   always_ff @(posedge clk)
   begin
      send_done <= 1'b0;
      ack_rcvd  <= 1'b0;
      stray_rx  <= 1'b0;
      if (!rst_n)
      begin
         cnt   <= 8'h00;
         sends <= 0;
      end
      else if (send_strobe)
      begin
         cnt   <= slow ? 8'h18 : 8'h06;
         sends <= sends + 1;
      end
      else if (cnt != 8'h00)
      begin
         cnt       <= cnt - 8'h01;
         send_done <= (cnt == 8'h04);
         ack_rcvd  <= (cnt == 8'h01) && ack_en;
         stray_rx  <= (cnt == 8'h01) && !ack_en;
      end
   end
endmodule
`default_nettype wire

//--- testbench/rmt_tx_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module rmt_tx_ctrl_properties #(
   parameter logic [63:0] FACTORY_SERIAL = 64'h0
) (
   // clock and reset
   input wire logic              clk,
   input wire logic              rst_n,
   // register bus
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [7:0]        paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   // traffic
   input wire logic              tx_busy,
   input wire logic              rx_valid,
   input wire logic              rx_bcast,
   input wire logic              rx_for_me,
   input wire logic [7:0]        channel_energy,
   input wire logic              send_strobe,
   input wire rmt_pkg::rmt_hdr_t hdr,
   input wire logic              ack_send,
   input wire logic              rx_accept
);
   logic [31:0] ctrl;
   logic [4:0]  sends;
   logic [4:0]  bmax;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ctrl shadow: threshold and retry setting are not visible at the ports
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         ctrl <= rmt_pkg::CTRL_RESET;
      else if (psel && penable && pwrite && paddr == rmt_pkg::ADDR_CTRL)
         ctrl <= pwdata;
   end
   // sends of the current packet, cleared while idle
   always_ff @(posedge clk)
   begin
      if (!rst_n || !tx_busy)
         sends <= 5'h00;
      else if (send_strobe)
         sends <= sends + 5'h01;
   end
   // broadcast send limit
   assign bmax = (ctrl[3:0] == 4'h0) ? 5'h01 : {1'b0, ctrl[3:0]} + 5'h02;
   a_src_serial: assert property (send_strobe && hdr.src_long |-> hdr.src == FACTORY_SERIAL)
      else $error("long source differs from serial");
   a_bcast_dst: assert property (send_strobe && hdr.bcast |-> hdr.dst == 64'h0000_0000_0000_FFFF)
      else $error("broadcast destination wrong");
   a_dst_form: assert property (send_strobe && !hdr.bcast |-> hdr.dst_long == (hdr.dst >= 64'hFFFE))
      else $error("destination form wrong");
   a_energy_gate: assert property (send_strobe |-> channel_energy <= ctrl[11:4])
      else $error("sent over a busy channel");
   a_busy_send: assert property (send_strobe |-> tx_busy)
      else $error("send while idle");
   a_unicast_tries: assert property (send_strobe && !hdr.bcast |-> sends < 5'h04)
      else $error("too many unicast sends");
   a_bcast_tries: assert property (send_strobe && hdr.bcast |-> sends < bmax)
      else $error("too many broadcast sends");
   a_ack_own: assert property (rx_valid && rx_for_me && !rx_bcast |=> ack_send)
      else $error("own packet not acknowledged");
   a_no_bcast_ack: assert property (rx_valid && rx_bcast |=> !ack_send)
      else $error("broadcast acknowledged");
   a_bcast_accept: assert property (rx_valid && rx_bcast |=> rx_accept)
      else $error("broadcast not accepted");
   a_serial_read: assert property (psel && !penable && !pwrite && paddr == rmt_pkg::ADDR_SERIAL_HI
      |=> prdata == FACTORY_SERIAL[63:32])
      else $error("serial high word wrong");
   c_bcast: cover property (send_strobe && hdr.bcast);
   c_long_src: cover property (send_strobe && hdr.src_long);
   c_rx_bcast: cover property (rx_valid && rx_bcast);
endmodule
bind rmt_tx_ctrl rmt_tx_ctrl_properties #(.FACTORY_SERIAL(FACTORY_SERIAL)) u_props (
   .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .tx_busy(tx_busy), .rx_valid(rx_valid),
   .rx_bcast(rx_bcast), .rx_for_me(rx_for_me), .channel_energy(channel_energy),
   .send_strobe(send_strobe), .hdr(hdr), .ack_send(ack_send), .rx_accept(rx_accept));
`default_nettype wire

//--- testbench/tb_rf_mac_tx_addressing_retry.sv
`timescale 1ns/1ps
`default_nettype none
module tb_rf_mac_tx_addressing_retry;
   localparam logic [63:0] SER = 64'h5A5A_C3C3_1E1E_7887; // arbitrary value
   // own short, dest high, dest low, ctrl, flags (src long, dst long, bcast), sends
   typedef struct packed {
      logic [15:0] own;
      logic [31:0] dh;
      logic [31:0] dl;
      logic [31:0] ctrl;
      logic [2:0]  fl;
      logic [3:0]  n;
   } rmt_row_t;
   localparam rmt_row_t ROWS [0:6] = '{
      {16'h0001, 32'h0, 32'h0002, 32'h0800, 3'b000, 4'h1},
      {16'hFFFF, 32'h0, 32'h1234, 32'h3803, 3'b100, 4'h1},
      {16'hFFFE, 32'h11112222, 32'h33334444, 32'h10800, 3'b110, 4'h1},
      {16'h0005, 32'h0, 32'hFFFE, 32'h0800, 3'b010, 4'h1},
      {16'h0005, 32'h0, 32'hFFFF, 32'h0800, 3'b001, 4'h1},
      {16'h0005, 32'h0, 32'hFFFF, 32'h0802, 3'b001, 4'h4},
      {16'h0005, 32'h1, 32'hFFFF, 32'h0800, 3'b010, 4'h1}};
   logic              clk = 1'b0;
   logic              rst_n, psel, penable, pwrite, tx_req, rxv, rx_bcast, rx_for_me, rx_valid;
   logic              rx_is_poll, sleep_cond, cmd_seq, cyclic_wake, pin_wake, ack_en, slow;
   logic              pready, pslverr, tx_busy, ack_rcvd, send_done, send_strobe, stray;
   logic              ack_send, rx_accept, poll_send;
   logic [1:0]        op_mode;
   logic [7:0]        paddr, channel_energy;
   logic [31:0]       pwdata, prdata, q;
   logic [63:0]       rx_src;
   rmt_pkg::rmt_hdr_t hdr, h;
   rmt_row_t          r;
   int                sends, n, failures, comparisons;
   assign rx_valid = rxv | stray;
   always #2.5 clk = ~clk;
   rmt_tx_ctrl #(.FACTORY_SERIAL(SER), .SLOT_US_CYC(4)) DUT (.clk(clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .tx_req(tx_req), .tx_busy(tx_busy), .rx_valid(rx_valid),
      .rx_bcast(rx_bcast), .rx_for_me(rx_for_me), .rx_src(rx_src), .rx_is_poll(rx_is_poll),
      .sleep_cond(sleep_cond), .cmd_seq(cmd_seq), .cyclic_wake(cyclic_wake), .pin_wake(pin_wake),
      .channel_energy(channel_energy), .ack_rcvd(ack_rcvd), .send_done(send_done),
      .send_strobe(send_strobe), .hdr(hdr), .ack_send(ack_send), .rx_accept(rx_accept),
      .poll_send(poll_send), .op_mode(op_mode));
   rmt_radio_model u_radio (.clk(clk), .rst_n(rst_n), .send_strobe(send_strobe), .ack_en(ack_en),
      .slow(slow), .send_done(send_done), .ack_rcvd(ack_rcvd), .stray_rx(stray), .sends(sends));
   task automatic finish_test;
      $display("comparisons=%0d failures=%0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one transfer, then one idle cycle so psel never changes twice at one edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clk);
      penable <= 1'b1;
      for (k = 0; k < 20; k++)
      begin
         @(posedge clk);
         if (pready === 1'b1)
            break;
      end
      q = prdata;
      {psel, penable} <= 2'b00;
      if (k >= 20)
      begin
         failures++;
         finish_test();
      end
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   // host request held until the sequencer takes it; header caught at the send
   task automatic send_pkt();
      int k;
      int s0;
      logic seen;
      s0 = sends;
      seen = 1'b0;
      h = '0;
      tx_req <= 1'b1;
      for (k = 0; k < 3000; k++)
      begin
         @(posedge clk);
         if (send_strobe === 1'b1)
            h = hdr;
         if (tx_busy === 1'b1)
            seen = 1'b1;
         else if (seen)
            break;
         if (seen)
            tx_req <= 1'b0;
      end
      if (k >= 3000)
      begin
         failures++;
         finish_test();
      end
      n = sends - s0;
   endtask
   task automatic rx_pulse();
      rxv <= 1'b1;
      @(posedge clk);
      rxv <= 1'b0;
      @(posedge clk);
   endtask
   // main sequence
   initial
   begin
      {rst_n, psel, penable, pwrite, tx_req, rxv, rx_bcast, rx_for_me} = '0;
      {rx_is_poll, sleep_cond, cmd_seq, cyclic_wake, pin_wake, ack_en, slow} = '0;
      {paddr, pwdata, rx_src, channel_energy} = {8'h00, 32'h0, 64'h0, 8'h10};
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(rmt_pkg::ADDR_CTRL);
      chk(q, rmt_pkg::CTRL_RESET);
      wr(rmt_pkg::ADDR_SERIAL_HI, 32'h0);
      rd(rmt_pkg::ADDR_SERIAL_HI);
      chk(q, SER[63:32]);
      rd(rmt_pkg::ADDR_SERIAL_LO);
      chk(q, SER[31:0]);
      rd(8'h3C);
      chk(q, 32'h0);
      wr(rmt_pkg::ADDR_TIMING, 32'h0);
      for (int i = 0; i < 7; i++)
      begin
         r = ROWS[i];
         ack_en <= !r.fl[0];
         slow <= i[0];
         wr(rmt_pkg::ADDR_OWN_SHORT, {16'h0, r.own});
         wr(rmt_pkg::ADDR_DEST_HI, r.dh);
         wr(rmt_pkg::ADDR_DEST_LO, r.dl);
         wr(rmt_pkg::ADDR_CTRL, r.ctrl);
         wr(rmt_pkg::ADDR_COMMAND, 32'h4);
         send_pkt();
         chk(n, r.n);
         chk(h.src, r.fl[2] ? SER : {48'h0, r.own});
         chk({h.src_long, h.bcast, h.dst}, {r.fl[2], r.fl[0], r.dh, r.dl});
         chk(h.dst_long | r.fl[0], r.fl[1] | r.fl[0]);
         rd(rmt_pkg::ADDR_STATUS);
         chk({q[5], q[1], q[0]}, {r.fl[0], 2'b01});
      end
      // peer stays silent: three resends, then the failure flag
      ack_en <= 1'b0;
      send_pkt();
      chk(n, 4);
      rd(rmt_pkg::ADDR_STATUS);
      chk(q[1], 1'b1);
      ack_en <= 1'b1;
      send_pkt();
      chk(n, 1);
      // busy channel: nothing leaves, assessment failure flagged
      channel_energy <= 8'hF0;
      send_pkt();
      chk(n, 0);
      rd(rmt_pkg::ADDR_STATUS);
      chk(q[2], 1'b1);
      channel_energy <= 8'h10;
      // coordinator with sleep on: two held, third refused, poll for their shared destination frees both
      wr(rmt_pkg::ADDR_CTRL, 32'h10800);
      wr(rmt_pkg::ADDR_TIMING, 32'h100);
      wr(rmt_pkg::ADDR_COMMAND, 32'h4);
      repeat (3) send_pkt();
      chk(n, 0);
      rd(rmt_pkg::ADDR_STATUS);
      chk({q[6], q[3]}, 2'b11);
      {rx_src, rx_is_poll} <= {64'h1_0000_FFFF, 1'b1};
      rx_pulse();
      rx_is_poll <= 1'b0;
      rd(rmt_pkg::ADDR_STATUS);
      chk(q[6], 1'b0);
      wr(rmt_pkg::ADDR_TIMING, 32'h0);
      send_pkt();
      chk(n, 1);
      wr(rmt_pkg::ADDR_CTRL, 32'h0800);
      wr(rmt_pkg::ADDR_COMMAND, 32'h2);
      rd(rmt_pkg::ADDR_OWN_SHORT);
      chk(q[15:0], 16'hFFFE);
      rx_for_me <= 1'b1;
      rx_pulse();
      chk(ack_send, 1'b1);
      {rx_for_me, rx_bcast} <= 2'b01;
      rx_pulse();
      chk({rx_accept, ack_send}, 2'b10);
      rx_bcast <= 1'b0;
      wr(rmt_pkg::ADDR_COMMAND, 32'h1);
      chk(poll_send, 1'b1);
      cmd_seq <= 1'b1;
      repeat (2) @(posedge clk);
      chk(op_mode, 2'h3);
      cmd_seq <= 1'b0;
      @(posedge clk);
      finish_test();
   end
endmodule
`default_nettype wire
